/* hdl/ssm_host_ctrl.sv */
/*
 * Host controller for the overlay (one-time-lockable) mode of a parallel
 * flash: runs entry, exit, program, read, lock-bit query and hardware
 * reset sequences on command from an Avalon-MM slave port.
 * Assumes the flash data bus is resolved outside from dq_oe_n, and that
 * dq input is asynchronous to clk.
 */
`timescale 1ns/10ps
`include "ssm_params.svh"

// Behaviour
// RQ1 - Overlay holds 128 words; accesses beyond it in first sector are refused.
// RQ2 - Lock indicator is read on data bit 7 at autoselect location 03h.
// RQ3 - Power-up or hardware reset leaves overlay mode for the normal array.
// RQ4 - Outside the first sector, accesses reach the normal array in overlay mode.
// RQ5 - Overlay mode lasts until the exit sequence or power loss.
// RQ6 - Overlay is unreachable while an internal program runs; wait completion.
// RQ7 - Accelerated programming and unlock bypass are off in overlay mode.
// RQ8 - Serialized parts carry a random serial number in words 0 to 7.
// RQ9 - Factory-locked overlay is write protected, lock bit reads 1.
// RQ10 - Customer-lockable overlay ships unprotected, lock bit 0, programmable.
// RQ11 - Customer-locked overlay keeps lock bit 0 forever.
// RQ12 - Overlay is programmed and locked once; never unlocked afterwards.
// RQ13 - After lock and verify the host issues the exit sequence.
// RQ14 - Entry: AA to 555, 55 to 2AA, 88 to 555; byte mode AAA/555/AAA.
// RQ15 - Exit: AA to 555, 55 to 2AA, 90 to 555, 00 anywhere.
// RQ16 - Program: two unlocks, A0 to 555, data at target, then poll.
// RQ17 - Overlay reads and customer programming use first-sector addresses.
// RQ18 - Program to a protected area is ignored; device returns to read.
// RQ19 - Reset low for minimum pulse aborts operations, returns to array read.
// RQ20 - A mismatched command write abandons the sequence back to read.
module ssm_host_ctrl
    import ssm_pkg::*;
#(
    parameter int unsigned POLL_MAX = 65536
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output ssm_pins_t        flash_pins,
    input  wire logic [15:0] flash_dq_in
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ssm_state_t  state_ff;
    ssm_pins_t   pins_ff;
    logic [31:0] rdata_ff;
    logic        wait_ff;
    logic [2:0]  cmd_ff;
    logic [2:0]  idx_ff;
    logic [4:0]  cnt_ff;
    logic [16:0] poll_ff;
    logic [23:0] addr_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rd_ff;
    logic [15:0] dq_meta_ff;
    logic [15:0] dq_sync_ff;
    logic        byte_ff;
    logic        accel_ff;
    logic        ovl_ff;
    logic        lock_ff;
    logic        lvld_ff;
    logic [2:0]  err_ff;
    logic [2:0]  nxt_err;

    function automatic ssm_step_t step_of(input logic [2:0] c, input logic [2:0] i);
        step_of = '{K_END, A_USER, 16'h0000};
        if (c != `SSM_CMD_READ && i == 3'h0) begin
            step_of = '{K_WR, A_UNL1, `SSM_D_UNL1};
        end else if (c != `SSM_CMD_READ && i == 3'h1) begin
            step_of = '{K_WR, A_UNL2, `SSM_D_UNL2};
        end else begin
            case (c)
                `SSM_CMD_ENTER: if (i == 3'h2) step_of = '{K_WR, A_UNL1, `SSM_D_ENTER}; // RQ14
                `SSM_CMD_EXIT: begin
                    if (i == 3'h2) step_of = '{K_WR, A_UNL1, `SSM_D_EXIT}; // RQ15
                    if (i == 3'h3) step_of = '{K_WR, A_USER, `SSM_D_EXIT2}; // RQ15
                end
                `SSM_CMD_PROG: begin
                    if (i == 3'h2) step_of = '{K_WR, A_UNL1, `SSM_D_PROG}; // RQ16
                    if (i == 3'h3) step_of = '{K_WD, A_USER, 16'h0000}; // RQ16
                    if (i == 3'h4) step_of = '{K_POLL, A_USER, 16'h0000}; // RQ16
                end
                `SSM_CMD_READ: if (i == 3'h0) step_of = '{K_RD, A_USER, 16'h0000};
                `SSM_CMD_LOCK: begin
                    if (i == 3'h2) step_of = '{K_WR, A_UNL1, `SSM_D_ASEL}; // RQ2
                    if (i == 3'h3) step_of = '{K_RD, A_LOCK, 16'h0000}; // RQ2
                    if (i == 3'h4) step_of = '{K_WR, A_LOCK, `SSM_D_RESET};
                end
                default: step_of = '{K_END, A_USER, 16'h0000};
            endcase
        end
    endfunction : step_of

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire        req      = avs_read | avs_write;
    wire        wr_en    = avs_write & ~wait_ff;
    wire        wr_ctrl  = wr_en && avs_address == `SSM_REG_CTRL;
    wire        wr_stat  = wr_en && avs_address == `SSM_REG_STATUS;
    wire [2:0]  new_cmd  = avs_writedata[2:0];
    wire        busy     = state_ff != S_IDLE;
    wire        in_first = addr_ff[23:`SSM_SECT_AW] == '0;
    wire        beyond   = addr_ff[`SSM_SECT_AW-1:0] >= `SSM_SECT_AW'(`SSM_OVL_WORDS);
    wire        rng_bad  = ovl_ff && in_first && beyond &&
                           (new_cmd == `SSM_CMD_READ || new_cmd == `SSM_CMD_PROG); // RQ1
    // Lock query would collide with the exit sequence's 90h write; re-entry is refused too
    wire        ref_bad  = busy || (ovl_ff && (new_cmd == `SSM_CMD_LOCK ||
                           new_cmd == `SSM_CMD_ENTER)) || new_cmd == 3'h0 || new_cmd == 3'h7;
    wire        start    = wr_ctrl && !ref_bad && !rng_bad;
    ssm_step_t  st;
    assign st = step_of(cmd_ff, idx_ff);
    wire [23:0] a_unl1   = byte_ff ? `SSM_UNL1_B : `SSM_UNL1_W; // RQ14
    wire [23:0] a_unl2   = byte_ff ? `SSM_UNL2_B : `SSM_UNL2_W; // RQ14
    wire [23:0] st_addr  = st.asel == A_UNL1 ? a_unl1 :
                           st.asel == A_UNL2 ? a_unl2 :
                           st.asel == A_LOCK ? `SSM_LOCK_ADDR : addr_ff; // RQ4 RQ17
    wire [15:0] st_data  = st.kind == K_WD ? wdata_ff : st.data;
    wire        poll_ok  = dq_sync_ff[7] == wdata_ff[7]; // RQ6
    wire        poll_end = poll_ff == 17'(POLL_MAX - 1);
    wire [31:0] status   = {25'h0, err_ff, lvld_ff, lock_ff, ovl_ff, busy};
    wire [31:0] ctrl_rd  = {26'h0, accel_ff, byte_ff, 1'b0, cmd_ff};
    wire [31:0] rd_mux   = avs_address == `SSM_REG_CTRL   ? ctrl_rd :
                           avs_address == `SSM_REG_ADDR   ? {8'h0, addr_ff} :
                           avs_address == `SSM_REG_WDATA  ? {16'h0, wdata_ff} :
                           avs_address == `SSM_REG_STATUS ? status :
                           avs_address == `SSM_REG_RDATA  ? {16'h0, rd_ff} : 32'h0;
    wire        rd_done  = state_ff == S_RLOW && cnt_ff == 5'h0;
    wire        to_set   = rd_done && st.kind == K_POLL && !poll_ok && poll_end;
    // Hardware sets win over a software clear in the same cycle
    always_comb begin
        nxt_err = err_ff & ~(wr_stat ? avs_writedata[`SSM_ST_ETO:`SSM_ST_EREF] : 3'h0);
        nxt_err = nxt_err | {to_set, wr_ctrl & rng_bad, wr_ctrl & ref_bad & ~rng_bad};
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign flash_pins      = pins_ff;

    // ------------------------------------------------------------------
    // Bus slave and registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
            addr_ff  <= 24'h0;
            wdata_ff <= 16'h0;
            byte_ff  <= 1'b0;
            accel_ff <= 1'b0;
            err_ff   <= 3'h0;
        end else begin
            wait_ff <= !(req && wait_ff);
            err_ff  <= nxt_err;
            if (req && wait_ff) rdata_ff <= rd_mux;
            if (wr_en && avs_address == `SSM_REG_ADDR) addr_ff <= avs_writedata[23:0];
            if (wr_en && avs_address == `SSM_REG_WDATA) wdata_ff <= avs_writedata[15:0];
            if (wr_ctrl && !busy) begin
                byte_ff  <= avs_writedata[`SSM_CTRL_BYTE];
                accel_ff <= avs_writedata[`SSM_CTRL_ACCEL];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_meta_ff <= 16'h0;
            dq_sync_ff <= 16'h0;
        end else begin
            dq_meta_ff <= flash_dq_in;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= S_RST;
            cmd_ff   <= 3'h0;
            idx_ff   <= 3'h0;
            cnt_ff   <= 5'(`SSM_RP_CYC);
            poll_ff  <= 17'h0;
            rd_ff    <= 16'h0;
            ovl_ff   <= 1'b0;
            lock_ff  <= 1'b0;
            lvld_ff  <= 1'b0;
            pins_ff  <= '{24'h0, 16'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0}; // RQ3 RQ19
        end else begin
            // Held off for the whole entry sequence: the flash switches before ovl_ff
            pins_ff.accel <= accel_ff & ~ovl_ff & ~(busy && cmd_ff == `SSM_CMD_ENTER); // RQ7
            case (state_ff)
                S_IDLE: if (start) begin
                    cmd_ff   <= new_cmd;
                    idx_ff   <= 3'h0;
                    poll_ff  <= 17'h0;
                    cnt_ff   <= 5'(`SSM_RP_CYC);
                    state_ff <= new_cmd == `SSM_CMD_HWRST ? S_RST : S_NEXT;
                end
                S_NEXT: begin
                    pins_ff.addr <= st_addr;
                    case (st.kind)
                        K_WR, K_WD: begin
                            pins_ff.dq_out  <= st_data;
                            pins_ff.dq_oe_n <= 1'b0;
                            pins_ff.ce_n    <= 1'b0;
                            state_ff        <= S_WSET;
                        end
                        K_RD, K_POLL: begin
                            pins_ff.ce_n <= 1'b0;
                            pins_ff.oe_n <= 1'b0;
                            cnt_ff       <= 5'(`SSM_ACCESS_CYC - 1);
                            state_ff     <= S_RLOW;
                        end
                        default: begin
                            if (cmd_ff == `SSM_CMD_ENTER) ovl_ff <= 1'b1; // RQ5 RQ14
                            if (cmd_ff == `SSM_CMD_EXIT) ovl_ff <= 1'b0; // RQ5 RQ13 RQ15
                            state_ff <= S_IDLE;
                        end
                    endcase
                end
                S_WSET: begin
                    pins_ff.we_n <= 1'b0;
                    cnt_ff       <= 5'(`SSM_WP_CYC - 1);
                    state_ff     <= S_WLOW;
                end
                S_WLOW: if (cnt_ff == 5'h0) begin
                    pins_ff.we_n <= 1'b1;
                    state_ff     <= S_WHOLD;
                end else begin
                    cnt_ff <= cnt_ff - 5'h1;
                end
                S_WHOLD: begin
                    pins_ff.dq_oe_n <= 1'b1;
                    pins_ff.ce_n    <= 1'b1;
                    idx_ff          <= idx_ff + 3'h1;
                    state_ff        <= S_NEXT;
                end
                S_RLOW: if (cnt_ff == 5'h0) begin
                    pins_ff.ce_n <= 1'b1;
                    pins_ff.oe_n <= 1'b1;
                    rd_ff        <= dq_sync_ff;
                    state_ff     <= S_NEXT;
                    if (cmd_ff == `SSM_CMD_LOCK) begin
                        lock_ff <= dq_sync_ff[`SSM_LOCK_DQ]; // RQ2 RQ9 RQ10 RQ11
                        lvld_ff <= 1'b1;
                    end
                    // Polling repeats the read until bit 7 matches or the count runs out
                    if (st.kind != K_POLL || poll_ok || poll_end) idx_ff <= idx_ff + 3'h1; // RQ6
                    else poll_ff <= poll_ff + 17'h1;
                end else begin
                    cnt_ff <= cnt_ff - 5'h1;
                end
                S_RST: begin
                    pins_ff.rst_n <= 1'b0; // RQ19
                    pins_ff.ce_n  <= 1'b1;
                    pins_ff.oe_n  <= 1'b1;
                    pins_ff.we_n  <= 1'b1;
                    pins_ff.dq_oe_n <= 1'b1;
                    ovl_ff        <= 1'b0; // RQ3
                    if (cnt_ff == 5'h0) begin
                        pins_ff.rst_n <= 1'b1;
                        cnt_ff        <= 5'(`SSM_RH_CYC);
                        state_ff      <= S_RREC;
                    end else begin
                        cnt_ff <= cnt_ff - 5'h1;
                    end
                end
                S_RREC: if (cnt_ff == 5'h0) state_ff <= S_IDLE;
                        else cnt_ff <= cnt_ff - 5'h1;
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_accel_off_ovl: assert property (ovl_ff |=> !pins_ff.accel) // RQ7
        else $error("accel driven in overlay mode");
    a_reset_exits: assert property (!pins_ff.rst_n |=> !ovl_ff) // RQ3
        else $error("overlay kept during flash reset");
    a_reset_width: assert property ($fell(pins_ff.rst_n) |-> !pins_ff.rst_n [*8]) // RQ19
        else $error("flash reset pulse too short");
    a_enter_only: assert property ($rose(ovl_ff) |-> $past(cmd_ff) == `SSM_CMD_ENTER) // RQ5
        else $error("overlay entered without entry");
    a_exit_only: assert property ($fell(ovl_ff) |-> // RQ5
        ($past(cmd_ff) == `SSM_CMD_EXIT || $past(state_ff) == S_RST))
        else $error("overlay left without exit or reset");
    a_range_refuse: assert property (wr_ctrl && rng_bad && !busy |=> err_ff[1] && !busy) // RQ1
        else $error("out of range overlay access started");
    a_lock_refuse: assert property (wr_ctrl && ovl_ff && !busy && // RQ2
        new_cmd == `SSM_CMD_LOCK |=> state_ff == S_IDLE && err_ff[0])
        else $error("lock query in overlay mode");
    a_write_drive: assert property (!pins_ff.we_n |-> !pins_ff.dq_oe_n && pins_ff.oe_n) // RQ14
        else $error("write strobe without data drive");
    a_enter_data: assert property ($fell(pins_ff.we_n) && cmd_ff == `SSM_CMD_ENTER // RQ14
        && idx_ff == 3'h2 |-> pins_ff.dq_out == `SSM_D_ENTER)
        else $error("wrong entry command word");
    a_prog_poll: assert property (state_ff == S_RLOW && st.kind == K_POLL // RQ16
        |-> cmd_ff == `SSM_CMD_PROG && !pins_ff.oe_n)
        else $error("poll outside program");

    c_enter: cover property ($rose(ovl_ff));
    c_exit: cover property ($fell(ovl_ff) && cmd_ff == `SSM_CMD_EXIT);
    c_prog_poll: cover property (rd_done && st.kind == K_POLL && poll_ok);
    c_lock_read: cover property ($rose(lvld_ff));
endmodule : ssm_host_ctrl

/* pkg/ssm_params.svh */
/*
 * Constants of the overlay-mode flash controller: register map, fields,
 * command words, flash addresses and timing counts.
 * Assumes a 40 MHz system clock and a flash in word mode, 16-bit data.
 */
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map (word index on the Avalon address)
// ----------------------------------------------------------------------
`define SSM_REG_CTRL     3'h0
`define SSM_REG_ADDR     3'h1
`define SSM_REG_WDATA    3'h2
`define SSM_REG_STATUS   3'h3
`define SSM_REG_RDATA    3'h4
`define SSM_CTRL_BYTE    4
`define SSM_CTRL_ACCEL   5
`define SSM_ST_BUSY      0
`define SSM_ST_OVL       1
`define SSM_ST_LOCK      2
`define SSM_ST_LVLD      3
`define SSM_ST_EREF      4
`define SSM_ST_ERNG      5
`define SSM_ST_ETO       6
// ----------------------------------------------------------------------
// Command codes written to the control register
// ----------------------------------------------------------------------
`define SSM_CMD_ENTER    3'h1
`define SSM_CMD_EXIT     3'h2
`define SSM_CMD_PROG     3'h3
`define SSM_CMD_READ     3'h4
`define SSM_CMD_LOCK     3'h5
`define SSM_CMD_HWRST    3'h6
// ----------------------------------------------------------------------
// Flash command addresses and data
// ----------------------------------------------------------------------
`define SSM_UNL1_W       24'h000555
`define SSM_UNL2_W       24'h0002aa
`define SSM_UNL1_B       24'h000aaa
`define SSM_UNL2_B       24'h000555
`define SSM_LOCK_ADDR    24'h000003
`define SSM_LOCK_DQ      7
`define SSM_D_UNL1       16'h00aa
`define SSM_D_UNL2       16'h0055
`define SSM_D_ENTER      16'h0088
`define SSM_D_EXIT       16'h0090
`define SSM_D_EXIT2      16'h0000
`define SSM_D_PROG       16'h00a0
`define SSM_D_ASEL       16'h0090
`define SSM_D_RESET      16'h00f0
`define SSM_SECT_AW      16
`define SSM_OVL_WORDS    128
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SSM_CLK_NS       25
`define SSM_T_WP_NS      35
`define SSM_T_ACCESS_NS  90
`define SSM_T_RP_NS      500
`define SSM_T_RH_NS      50
`define SSM_SYNC_CYC     2
`define SSM_CYC(ns)      (((ns) + `SSM_CLK_NS - 1) / `SSM_CLK_NS)
`define SSM_WP_CYC       `SSM_CYC(`SSM_T_WP_NS)
`define SSM_ACCESS_CYC   (`SSM_CYC(`SSM_T_ACCESS_NS) + `SSM_SYNC_CYC)
`define SSM_RP_CYC       `SSM_CYC(`SSM_T_RP_NS)
`define SSM_RH_CYC       `SSM_CYC(`SSM_T_RH_NS)

`endif

/* pkg/ssm_pkg.sv */
/*
 * Types of the overlay-mode flash controller.
 * Assumes ssm_params.svh is on the include path.
 */
package ssm_pkg;
    typedef enum logic [2:0] {K_WR, K_WD, K_RD, K_POLL, K_END} ssm_kind_t;
    typedef enum logic [1:0] {A_UNL1, A_UNL2, A_USER, A_LOCK} ssm_asel_t;
    typedef struct packed {
        ssm_kind_t   kind;
        ssm_asel_t   asel;
        logic [15:0] data;
    } ssm_step_t;
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe_n;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        rst_n;
        logic        accel;
    } ssm_pins_t;
    typedef enum {S_IDLE, S_NEXT, S_WSET, S_WLOW, S_WHOLD, S_RLOW, S_RST, S_RREC} ssm_state_t;
endpackage : ssm_pkg

/* testbench/ssm_flash_model.sv */
/* Behavioural flash with an overlay region, seen from its pins.
   Assumes the bench resolves the data bus and the controller holds ce_n low
   across the rising edge of we_n. */
`timescale 1ns/10ps
module ssm_flash_model
    import ssm_pkg::*;
#(
    parameter logic LOCK_BIT = 1'b0,
    parameter int   POLL_N   = 2
) (
    input  wire ssm_pins_t   pins,
    input  wire logic        byte_mode,
    output logic [15:0]      dq,
    output logic             ovl
);
    logic [15:0] ovm [128];
    logic [15:0] mem [int];
    logic [15:0] last, drv, pdata, d;
    int          st, pend;
    wire  [23:0] a1   = byte_mode ? 24'h000aaa : 24'h000555;
    wire  [23:0] a2   = byte_mode ? 24'h000555 : 24'h0002aa;
    wire         sec0 = pins.addr[23:16] == 8'h00;
    wire         act  = !pins.ce_n && !pins.oe_n && pins.rst_n;

    function automatic logic [15:0] arr(input logic [23:0] x);
        return mem.exists(x) ? mem[x] : x[15:0] ^ {x[23:16], 8'h3c};
    endfunction : arr

    initial begin
        for (int i = 0; i < 128; i++) ovm[i] = (i < 8) ? 16'h1000 + 16'(i) : 16'hffff;
        st = 0;
        pend = 0;
        ovl = 1'b0;
        last = 16'h0000;
    end
    // --------------------------------------------------------------
    // Command interpreter
    // --------------------------------------------------------------
    always @(posedge pins.we_n or negedge pins.rst_n) begin
        d = pins.dq_out;
        if (!pins.rst_n) begin
            ovl = 1'b0;
            st = 0;
        end else if (!pins.ce_n) begin
            case (st)
                0: st = (d == 16'h00aa && pins.addr == a1) ? 1 : 0;
                1: st = (d == 16'h0055 && pins.addr == a2) ? 2 : 0;
                2: begin
                    if (pins.addr != a1) st = 0;
                    else if (d == 16'h0088) ovl = 1'b1;
                    st = (pins.addr != a1) ? 0 : (d == 16'h00a0) ? 3 : (d == 16'h0090) ? 4 : 0;
                end
                3: begin
                    pdata = d;
                    pend = POLL_N;
                    st = 0;
                    if (!(ovl && sec0)) mem[pins.addr] = arr(pins.addr) & d;
                    else if (pins.addr[15:7] == 9'h0 && !LOCK_BIT) begin
                        ovm[pins.addr[6:0]] &= d;
                    end
                end
                default: begin
                    if (d == 16'h0000) ovl = 1'b0;
                    if (d == 16'h0000 || d == 16'h00f0) st = 0;
                end
            endcase
        end
    end
    // --------------------------------------------------------------
    // Read path; a released bus shows the inverse of the last word
    // --------------------------------------------------------------
    // Program ends only after POLL_N polls, so data polling is really used
    always @(posedge pins.oe_n) if (pend > 0) pend = pend - 1;
    always @* begin
        if (pend > 0) drv = {8'h00, ~pdata[7], 7'h00};
        else if (st == 4 && pins.addr[7:0] == 8'h03) drv = {8'h00, LOCK_BIT, 7'h00};
        else if (ovl && sec0 && pins.addr[15:7] == 9'h0) drv = ovm[pins.addr[6:0]];
        else if (ovl && sec0) drv = 16'hdead;
        else drv = arr(pins.addr);
        if (act) last = drv;
        dq = act ? drv : ~last;
    end
endmodule : ssm_flash_model

/* testbench/tb.sv */
/* Self-checking bench: drives the Avalon port, checks status and data.
   Assumes ssm_params.svh on the include path and the flash model. */
`timescale 1ns/10ps
`include "ssm_params.svh"
module tb
    import ssm_pkg::*;
();
    // --------------------------------------------------------------
    // Wiring
    // --------------------------------------------------------------
    logic        clk, reset_n, avs_read, avs_write, bmode, accel_seen, movl;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        avs_waitrequest;
    logic [15:0] mdq, d;
    wire  [15:0] dq_in;
    ssm_pins_t   pins;
    int          fails, check_count, seed;
    logic [23:0] a, pa;

    ssm_host_ctrl #(.POLL_MAX(4)) u_dut (.clk(clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flash_pins(pins), .flash_dq_in(dq_in));
    ssm_flash_model u_flash (.pins(pins), .byte_mode(bmode), .dq(mdq), .ovl(movl));
    assign dq_in = pins.dq_oe_n ? mdq : pins.dq_out;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (movl && pins.accel) accel_seen <= 1'b1;
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request is held until the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= ad;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) fails++;
    endtask : bus

    task automatic idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, `SSM_REG_STATUS, 32'h0);
            n++;
        end while (q[`SSM_ST_BUSY] !== 1'b0 && n < 400);
        if (n >= 400) fails++;
    endtask : idle

    task automatic cmd(input logic [2:0] c, input logic [1:0] fl);
        bus(1'b1, `SSM_REG_CTRL, {26'h0, fl, 1'b0, c});
        idle();
    endtask : cmd

    task automatic rd_at(input logic [23:0] ad);
        bus(1'b1, `SSM_REG_ADDR, {8'h0, ad});
        cmd(`SSM_CMD_READ, 2'b00);
        bus(1'b0, `SSM_REG_RDATA, 32'h0);
    endtask : rd_at

    function automatic logic [31:0] arr_exp(input logic [23:0] x);
        return {16'h0, x[15:0] ^ {x[23:16], 8'h3c}};
    endfunction : arr_exp

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        #1500000;
        fails++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        bmode = 1'b0;
        accel_seen = 1'b0;
        fails = 0;
        check_count = 0;
        seed = 32'h6e201c84;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        idle();
        chk("overlay after reset", 32'h0, {31'h0, q[`SSM_ST_OVL]});
        rd_at(24'h000003);
        chk("array word 3", arr_exp(24'h000003), q);
        $display("test reset done");
        cmd(`SSM_CMD_ENTER, 2'b00);
        chk("overlay flag", 32'h1, {31'h0, q[`SSM_ST_OVL]});
        chk("flash overlay", 32'h1, {31'h0, movl});
        for (int i = 0; i < 8; i += 7) begin
            rd_at(24'(i));
            chk("serial word", 32'h1000 + i, q);
        end
        for (int i = 0; i < 4; i++) begin
            a = 24'($random(seed));
            a[20] = 1'b1;
            rd_at(a);
            chk("array in overlay", arr_exp(a), q);
        end
        rd_at(24'h000080);
        bus(1'b0, `SSM_REG_STATUS, 32'h0);
        chk("range error", 32'h1, {31'h0, q[`SSM_ST_ERNG]});
        cmd(`SSM_CMD_ENTER, 2'b00);
        chk("second entry", 32'h3, {30'h0, q[`SSM_ST_EREF], q[`SSM_ST_OVL]});
        bus(1'b1, `SSM_REG_STATUS, 32'h70);
        bus(1'b0, `SSM_REG_STATUS, 32'h0);
        chk("errors cleared", 32'h0, {29'h0, q[6:4]});
        cmd(`SSM_CMD_LOCK, 2'b00);
        chk("lock in overlay", 32'h5, {29'h0, q[`SSM_ST_EREF], q[`SSM_ST_LVLD], q[`SSM_ST_OVL]});
        $display("test entry done");
        pa = {17'h0, 7'($random(seed) | 32'h8)};
        d = 16'($random(seed));
        bus(1'b1, `SSM_REG_ADDR, {8'h0, pa});
        bus(1'b1, `SSM_REG_WDATA, {16'h0, d});
        cmd(`SSM_CMD_PROG, 2'b10);
        chk("poll timeout", 32'h0, {31'h0, q[`SSM_ST_ETO]});
        rd_at(pa);
        chk("programmed word", {16'h0, d}, q);
        chk("accel in overlay", 32'h0, {31'h0, accel_seen});
        $display("test program done");
        bus(1'b1, `SSM_REG_ADDR, 32'($random(seed)) & 32'h00ffffff);
        cmd(`SSM_CMD_EXIT, 2'b00);
        chk("exit flag", 32'h0, {30'h0, movl, q[`SSM_ST_OVL]});
        rd_at(pa);
        chk("array after exit", arr_exp(pa), q);
        cmd(`SSM_CMD_LOCK, 2'b00);
        chk("lock bit", 32'h2, {30'h0, q[`SSM_ST_LVLD], q[`SSM_ST_LOCK]});
        $display("test exit and lock done");
        bmode <= 1'b1;
        cmd(`SSM_CMD_ENTER, 2'b11);
        chk("byte entry", 32'h3, {30'h0, movl, q[`SSM_ST_OVL]});
        chk("accel at entry", 32'h0, {31'h0, accel_seen});
        cmd(`SSM_CMD_HWRST, 2'b01);
        chk("reset exit", 32'h0, {30'h0, movl, q[`SSM_ST_OVL]});
        bmode <= 1'b0;
        $display("test byte and reset done");
        conclude();
    end
endmodule : tb
